// ===== src/pcs_pma.sv
// Purpose: 100 Mbps 4B/5B coding, delimiters, carrier sense and link qualification
// Assumes: i_lclk is the code-group clock shared with the MAC nibble path and the line side
// Notes: link timers run on i_mclk; levels cross by two flops, idle runs by a toggle
`timescale 1ns/10ps
module pcs_pma import pcs_pkg::*; #(
   parameter int LOCK_CNT = LOCK_CYCLES,
   parameter int WIN_CNT = WIN_CYCLES
) (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_lclk,
   input wire mii_tx_t i_mii_tx,
   input wire code_t i_rx_code,
   input wire logic i_dscr_lock,
   input wire logic i_link10_raw,
   input wire logic i_an_enable,
   input wire logic i_link_override,
   output logic o_mii_txclk,
   output logic o_mii_rxclk,
   output code_t o_tx_code,
   output mii_rx_t o_mii_rx,
   output logic o_link_stat,
   output logic o_link_stat_ext,
   output logic o_link_irq,
   output logic o_an_restart,
   output logic o_flp_req,
   output logic o_link10
);
   localparam int LW = $clog2(LOCK_CNT + 1);
   localparam int WW = $clog2(WIN_CNT + 1);
   localparam int RW = $clog2(IDLE_RUN + 1);
   localparam int HW = $clog2(MII_HALF + 1);

   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SSD_K = 2'b01, TX_DATA = 2'b10, TX_ESD_R = 2'b11} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SSD_K = 2'b01, RX_DATA = 2'b10, RX_ESD_R = 2'b11} rx_state_t;

   function automatic code_t pick(input logic [3*CG_W-1:0] sr, input int base);
      return sr[base -: CG_W];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // link domain reset release and level crossings into it
   logic lrst_meta_reg;
   logic lrst_n_reg;
   logic [3:0] lsync_meta_reg;
   logic [3:0] lsync_reg;
   logic link_up_reg;
   wire logic [3:0] lsync_in = {i_an_enable, i_link_override, link_up_reg, i_ce};
   wire logic ce_l = lsync_reg[0];
   wire logic tx_allowed = lsync_reg[1] | (lsync_reg[2] & ~lsync_reg[3]);

   always_ff @(posedge i_lclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lrst_meta_reg <= 1'b0;
         lrst_n_reg <= 1'b0;
      end else begin
         lrst_meta_reg <= 1'b1;
         lrst_n_reg <= lrst_meta_reg;
      end
   end

   always_ff @(posedge i_lclk or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         lsync_meta_reg <= 4'h0;
         lsync_reg <= 4'h0;
      end else begin
         lsync_meta_reg <= lsync_in;
         lsync_reg <= lsync_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit encoder, MII nibbles sampled on the rising link clock
   tx_state_t tx_state_reg;
   tx_state_t tx_state_next;
   code_t tx_code_reg;
   code_t tx_code_next;
   logic tx_en_d_reg;
   wire logic tx_start = i_mii_tx.en & ~tx_en_d_reg & tx_allowed;
   wire code_t tx_data_code = i_mii_tx.er ? CG_H : enc_nibble(i_mii_tx.d);

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_code_next = CG_IDLE;
      case (tx_state_reg)
         TX_IDLE: begin
            if (tx_start) begin
               tx_code_next = CG_J;
               tx_state_next = TX_SSD_K;
            end
         end
         TX_SSD_K: begin
            tx_code_next = CG_K;
            tx_state_next = TX_DATA;
         end
         TX_DATA: begin
            if (i_mii_tx.en) begin
               tx_code_next = tx_data_code;
            end else begin
               tx_code_next = CG_T;
               tx_state_next = TX_ESD_R;
            end
         end
         TX_ESD_R: begin
            tx_code_next = CG_R;
            tx_state_next = TX_IDLE;
         end
         default: begin
            tx_state_next = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_lclk or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         tx_state_reg <= TX_IDLE;
         tx_code_reg <= CG_IDLE;
         tx_en_d_reg <= 1'b0;
      end else if (ce_l) begin
         tx_state_reg <= tx_state_next;
         tx_code_reg <= tx_code_next;
         tx_en_d_reg <= i_mii_tx.en;
      end
   end

   assign o_tx_code = tx_code_reg;

   ////////////////////////////////////////////////////////////////////////////
   // receive alignment and decoder
   logic [3*CG_W-1:0] rx_sr_reg;
   logic [2:0] rx_off_reg;
   logic [2:0] rx_off_next;
   rx_state_t rx_state_reg;
   rx_state_t rx_state_next;
   mii_rx_t rx_out_reg;
   mii_rx_t rx_out_next;
   logic ssd_found;
   logic [2:0] ssd_off;
   logic [RW-1:0] idle_run_reg;
   logic idle_tog_reg;
   wire code_t rx_grp = pick(rx_sr_reg, 3 * CG_W - 1 - int'(rx_off_reg));
   wire code_t rx_nxt = pick(rx_sr_reg, 2 * CG_W - 1 - int'(rx_off_reg));
   wire logic [4:0] rx_dec = dec_group(rx_grp);
   wire logic rx_esd = (rx_grp == CG_T) && (rx_nxt == CG_R);
   wire logic rx_grp_bad = ~rx_dec[4] & ~rx_esd & (rx_grp != CG_IDLE);
   wire logic idle_in = (i_rx_code == CG_IDLE);
   wire logic idle_hit = idle_in && (idle_run_reg == RW'(IDLE_RUN - 1));

   // J must sit directly before K at the same offset, else no frame starts
   always_comb begin
      ssd_found = 1'b0;
      ssd_off = 3'h0;
      for (int o = 0; o < ALIGN_N; o++) begin
         if (!ssd_found && pick(rx_sr_reg, 3 * CG_W - 1 - o) == CG_J
             && pick(rx_sr_reg, 2 * CG_W - 1 - o) == CG_K) begin
            ssd_found = 1'b1;
            ssd_off = 3'(o);
         end
      end
   end

   always_comb begin
      rx_state_next = rx_state_reg;
      rx_off_next = rx_off_reg;
      rx_out_next = '0;
      case (rx_state_reg)
         RX_IDLE: begin
            if (ssd_found) begin
               rx_off_next = ssd_off;
               rx_out_next = '{dv: 1'b1, er: 1'b0, crs: 1'b1, d: NIB_PRE};
               rx_state_next = RX_SSD_K;
            end
         end
         RX_SSD_K: begin
            rx_out_next = '{dv: 1'b1, er: 1'b0, crs: 1'b1, d: NIB_PRE};
            rx_state_next = RX_DATA;
         end
         RX_DATA: begin
            if (rx_dec[4]) begin
               rx_out_next = '{dv: 1'b1, er: 1'b0, crs: 1'b1, d: rx_dec[3:0]};
            end else if (rx_esd) begin
               rx_state_next = RX_ESD_R;
            end else if (rx_grp == CG_IDLE) begin
               rx_out_next.er = 1'b1;
               rx_state_next = RX_IDLE;
            end else begin
               rx_out_next = '{dv: 1'b0, er: 1'b1, crs: 1'b1, d: NIB_ERR};
            end
         end
         RX_ESD_R: begin
            rx_state_next = RX_IDLE;
         end
         default: begin
            rx_state_next = RX_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_lclk or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         rx_sr_reg <= '0;
         rx_off_reg <= 3'h0;
         rx_state_reg <= RX_IDLE;
         rx_out_reg <= '0;
      end else if (ce_l) begin
         rx_sr_reg <= {rx_sr_reg[2*CG_W-1:0], i_rx_code};
         rx_off_reg <= rx_off_next;
         rx_state_reg <= rx_state_next;
         rx_out_reg <= rx_out_next;
      end
   end

   // the sixteenth idle of a run and every idle after it each flip the toggle once
   always_ff @(posedge i_lclk or negedge lrst_n_reg) begin
      if (!lrst_n_reg) begin
         idle_run_reg <= '0;
         idle_tog_reg <= 1'b0;
      end else if (ce_l) begin
         idle_run_reg <= !idle_in ? '0 : (idle_hit ? idle_run_reg : idle_run_reg + RW'(1));
         idle_tog_reg <= idle_tog_reg ^ idle_hit;
      end
   end

   assign o_mii_rx = rx_out_reg;

   ////////////////////////////////////////////////////////////////////////////
   // system clock side: crossings, MII clock and link qualification
   logic [2:0] msync_meta_reg;
   logic [2:0] msync_reg;
   logic idle_tog_d_reg;
   logic [HW-1:0] div_reg;
   logic mii_clk_reg;
   logic [LW-1:0] lock_cnt_reg;
   logic [WW-1:0] win_cnt_reg;
   logic seen_reg;
   logic irq_reg;
   logic an_restart_reg;
   logic flp_reg;
   logic link10_reg;
   wire logic [2:0] msync_in = {idle_tog_reg, i_link10_raw, i_dscr_lock};
   wire logic lock_s = msync_reg[0];
   wire logic link10_s = msync_reg[1];
   wire logic idle_evt = msync_reg[2] ^ idle_tog_d_reg;
   wire logic lock_done = (lock_cnt_reg == LW'(LOCK_CNT - 1));
   wire logic win_end = (win_cnt_reg == WW'(WIN_CNT - 1));
   wire logic div_end = (div_reg == HW'(MII_HALF - 1));
   wire logic link_rise = ~link_up_reg & lock_s & lock_done;
   wire logic link_drop = link_up_reg & (~lock_s | (win_end & ~(seen_reg | idle_evt)));
   wire logic link_up_next = link_rise | (link_up_reg & ~link_drop);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         msync_meta_reg <= 3'h0;
         msync_reg <= 3'h0;
      end else begin
         msync_meta_reg <= msync_in;
         msync_reg <= msync_meta_reg;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_reg <= '0;
         mii_clk_reg <= 1'b0;
      end else if (i_ce) begin
         div_reg <= div_end ? '0 : div_reg + HW'(1);
         mii_clk_reg <= mii_clk_reg ^ div_end;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         idle_tog_d_reg <= 1'b0;
         lock_cnt_reg <= '0;
         win_cnt_reg <= '0;
         seen_reg <= 1'b0;
         link_up_reg <= 1'b0;
      end else if (i_ce) begin
         idle_tog_d_reg <= msync_reg[2];
         lock_cnt_reg <= (!lock_s || link_drop) ? '0 : (lock_done ? lock_cnt_reg : lock_cnt_reg + LW'(1));
         win_cnt_reg <= (!link_up_reg || win_end) ? '0 : win_cnt_reg + WW'(1);
         seen_reg <= (!link_up_reg || win_end) ? idle_evt : (seen_reg | idle_evt);
         link_up_reg <= link_up_next;
      end
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_reg <= 1'b0;
         an_restart_reg <= 1'b0;
         flp_reg <= 1'b0;
         link10_reg <= 1'b0;
      end else if (i_ce) begin
         irq_reg <= link_drop;
         an_restart_reg <= link_drop & i_an_enable;
         flp_reg <= i_an_enable & ~link_up_next;
         link10_reg <= link10_s & ~lock_s;
      end
   end

   assign o_mii_txclk = mii_clk_reg;
   assign o_mii_rxclk = mii_clk_reg;
   assign o_link_stat = link_up_reg;
   assign o_link_stat_ext = link_up_reg;
   assign o_link_irq = irq_reg;
   assign o_an_restart = an_restart_reg;
   assign o_flp_req = flp_reg;
   assign o_link10 = link10_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_tx_idle_fill: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && tx_state_reg == TX_IDLE && !tx_start |=> tx_code_reg == CG_IDLE)
      else $error("idle fill missing");
   a_tx_ssd_pair: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && tx_state_reg == TX_IDLE && tx_start |=> tx_code_reg == CG_J ##1 tx_code_reg == CG_K)
      else $error("start delimiter wrong");
   a_tx_esd_pair: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      tx_code_reg == CG_T |=> tx_code_reg == CG_R)
      else $error("T not followed by R");
   a_tx_error_sym: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && tx_state_reg == TX_DATA && i_mii_tx.en && i_mii_tx.er |=> tx_code_reg == CG_H)
      else $error("H not sent on error");
   a_rx_preamble_out: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && rx_state_reg == RX_IDLE && ssd_found
      |=> (rx_out_reg.dv && rx_out_reg.crs && rx_out_reg.d == NIB_PRE) [*2])
      else $error("preamble nibbles missing");
   a_rx_false_end: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && rx_state_reg == RX_DATA && rx_grp == CG_IDLE
      |=> rx_out_reg.er && !rx_out_reg.crs ##1 !rx_out_reg.er)
      else $error("premature idle not flagged once");
   a_rx_invalid_sym: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && rx_state_reg == RX_DATA && rx_grp_bad |=> rx_out_reg.er && rx_out_reg.d == NIB_ERR)
      else $error("invalid group not flagged");
   a_rx_esd_crs: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && rx_state_reg == RX_DATA && rx_esd |=> !rx_out_reg.crs && !rx_out_reg.er)
      else $error("carrier held after T R");
   a_link_needs_lock: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $rose(link_up_reg) |-> $past(lock_cnt_reg) == LW'(LOCK_CNT - 1) && $past(lock_s))
      else $error("link up before lock time");
   a_link_fail_report: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      $fell(link_up_reg) |-> o_link_irq && (o_an_restart == $past(i_an_enable)))
      else $error("link failure not reported");
   a_tx_refused_idle: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && tx_state_reg == TX_IDLE && !tx_allowed |=> tx_code_reg == CG_IDLE)
      else $error("frame sent while not allowed");
   a_tx_data_code: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && tx_state_reg == TX_DATA && i_mii_tx.en && !i_mii_tx.er
      |=> tx_code_reg == enc_nibble($past(i_mii_tx.d)))
      else $error("data nibble encoded wrongly");
   a_rx_dv_clean: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      rx_out_reg.dv |-> rx_out_reg.crs && !rx_out_reg.er)
      else $error("data valid with error or no carrier");
   a_rx_crs_start: assert property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      ce_l && rx_state_reg == RX_IDLE && !ssd_found |=> !rx_out_reg.crs)
      else $error("carrier without start delimiter");
   a_link_window_drop: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      i_ce && link_up_reg && win_end && !seen_reg && !idle_evt |=> !link_up_reg)
      else $error("link kept without idle run");
   a_flp_link_down: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
      o_flp_req |-> !o_link_stat)
      else $error("pulse bursts while link up");

   c_tx_frame: cover property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      tx_code_reg == CG_K ##[1:200] tx_code_reg == CG_T);
   c_rx_frame: cover property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      rx_state_reg == RX_SSD_K ##[1:200] rx_state_reg == RX_ESD_R);
   c_rx_false_end: cover property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      rx_state_reg == RX_DATA && rx_grp == CG_IDLE);
   c_link_cycle: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
      $rose(link_up_reg) ##[1:1000] $fell(link_up_reg));
   c_tx_error_sym: cover property (@(posedge i_lclk) disable iff (!lrst_n_reg)
      tx_code_reg == CG_H);
endmodule

// ===== src/pcs_pkg.sv
// Purpose: constants, code groups and carrier types for the 100 Mbps coding and link block
// Assumes: i_mclk at 100 MHz; link logic on its own code-group clock
// Notes: code groups are 5 bits, msb first as printed in the coding table
package pcs_pkg;
   localparam int CLK_MHZ = 100;
   localparam int MII_MHZ = 25;
   localparam int MII_HALF = CLK_MHZ / (2 * MII_MHZ);
   localparam int LOCK_MS = 50;
   localparam int IDLE_WIN_US = 2000;
   localparam int LOCK_CYCLES = LOCK_MS * 1000 * CLK_MHZ;
   localparam int WIN_CYCLES = IDLE_WIN_US * CLK_MHZ;
   localparam int IDLE_RUN = 16;
   localparam int CG_W = 5;
   localparam int ALIGN_N = 5;

   typedef logic [CG_W-1:0] code_t;

   localparam code_t CG_IDLE = 5'h1f;
   localparam code_t CG_J = 5'h18;
   localparam code_t CG_K = 5'h11;
   localparam code_t CG_T = 5'h0d;
   localparam code_t CG_R = 5'h07;
   localparam code_t CG_H = 5'h04;
   localparam logic [3:0] NIB_PRE = 4'h5;
   localparam logic [3:0] NIB_ERR = 4'h5;

   typedef struct packed {
      logic en;
      logic er;
      logic [3:0] d;
   } mii_tx_t;

   typedef struct packed {
      logic dv;
      logic er;
      logic crs;
      logic [3:0] d;
   } mii_rx_t;

   function automatic code_t enc_nibble(input logic [3:0] n);
      code_t c;
      case (n)
         4'h0: c = 5'h1e;
         4'h1: c = 5'h09;
         4'h2: c = 5'h14;
         4'h3: c = 5'h15;
         4'h4: c = 5'h0a;
         4'h5: c = 5'h0b;
         4'h6: c = 5'h0e;
         4'h7: c = 5'h0f;
         4'h8: c = 5'h12;
         4'h9: c = 5'h13;
         4'ha: c = 5'h16;
         4'hb: c = 5'h17;
         4'hc: c = 5'h1a;
         4'hd: c = 5'h1b;
         4'he: c = 5'h1c;
         default: c = 5'h1d;
      endcase
      return c;
   endfunction

   // returns {valid, nibble}; valid only for data code groups
   function automatic logic [4:0] dec_group(input code_t c);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (enc_nibble(4'(i)) == c) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction
endpackage

// ===== test/mac_model.sv
// Purpose: MAC side of the transmit nibble path
// Assumes: i_lclk is the code-group clock that the block also runs on
// Notes: send() plays one frame; the data lines are inverted once as enable drops, then held
`timescale 1ns/10ps
module mac_model import pcs_pkg::*; (
   input wire logic i_lclk,
   output mii_tx_t o_tx
);
   initial o_tx = '0;
   // each entry is {er, d}; enable rises with the first preamble nibble
   // carrier sense is not watched for gap timing
   task automatic send(input logic [4:0] q[$]);
      foreach (q[i]) begin
         @(posedge i_lclk);
         o_tx <= {1'b1, q[i]};
      end
      @(posedge i_lclk);
      o_tx <= {2'b00, ~o_tx.d};
   endtask
endmodule

// ===== test/fast_ethernet_pcs_pma_tb_top.sv
// Purpose: self-checking bench for the coding, carrier and link block
// Assumes: link counts shortened to 200 and 800 system cycles
// Notes: outputs of the link domain are sampled on the falling link clock
`timescale 1ns/10ps
module fast_ethernet_pcs_pma_tb_top import pcs_pkg::*;;
   localparam code_t ENC[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
   logic i_mclk = 0, i_lclk = 0, i_reset_n = 0, i_ce = 1, i_dscr_lock = 0;
   logic i_link10_raw = 0, i_an_enable = 1, i_link_override = 0;
   logic txclk, rxclk, link, link_ext, irq, an_rst, flp, link10, p;
   code_t rx_code = 5'h1f;
   code_t tx_code;
   mii_tx_t tx;
   mii_rx_t rx;
   int fails = 0, compares = 0, irqs = 0, rsts = 0, n;
   logic [15:0] seed = 16'h0041;
   code_t txq[$], g[$];
   mii_rx_t rxq[$];
   logic [4:0] q[$];
   ////////////////////////////////////////////////////////////
   always #5 i_mclk = ~i_mclk;
   always begin
      if ($time == 0) #3;
      #40 i_lclk = ~i_lclk;
   end
   mac_model mac (.i_lclk(i_lclk), .o_tx(tx));
   pcs_pma #(.LOCK_CNT(200), .WIN_CNT(800)) DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce),
      .i_lclk(i_lclk), .i_mii_tx(tx), .i_rx_code(rx_code), .i_dscr_lock(i_dscr_lock),
      .i_link10_raw(i_link10_raw), .i_an_enable(i_an_enable), .i_link_override(i_link_override),
      .o_mii_txclk(txclk), .o_mii_rxclk(rxclk), .o_tx_code(tx_code), .o_mii_rx(rx),
      .o_link_stat(link), .o_link_stat_ext(link_ext), .o_link_irq(irq), .o_an_restart(an_rst),
      .o_flp_req(flp), .o_link10(link10));
   always @(negedge i_lclk) begin
      txq.push_back(tx_code);
      rxq.push_back(rx);
   end
   always @(negedge i_mclk) begin
      if (irq === 1'b1) irqs++;
      if (an_rst === 1'b1) rsts++;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic mii_rx_t rx_exp(input code_t c, input int i);
      mii_rx_t e;
      e = {3'b011, 4'h5};
      if (i < 2) begin
         e = {3'b101, 4'h5};
      end else begin
         for (int k = 0; k < 16; k++) begin
            if (ENC[k] == c) e = {3'b101, 4'(k)};
         end
      end
      return e;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wait_link(input logic v);
      int k;
      k = 0;
      while (link !== v) begin
         @(negedge i_mclk);
         k++;
         if (k > 2000) begin
            fails++;
            stop_test();
         end
      end
   endtask
   task automatic tx_frame(input bit ok);
      int j, bad;
      j = -1;
      bad = 0;
      txq.delete();
      mac.send(q);
      repeat (6) @(negedge i_lclk);
      foreach (txq[i]) begin
         if (j < 0 && txq[i] === CG_J) j = i;
         if (txq[i] !== CG_IDLE) bad++;
      end
      if (!ok) begin
         check(16'(bad), 16'h0000);
      end else begin
         if (j < 0) j = 0;
         check(16'({txq[j], txq[j+1]}), 16'({CG_J, CG_K}));
         for (int i = 2; i < q.size(); i++) begin
            check(16'(txq[j+i]), 16'(q[i][4] ? CG_H : ENC[q[i][3:0]]));
         end
         j = j + q.size();
         check(16'({txq[j], txq[j+1], txq[j+2]}), 16'({CG_T, CG_R, CG_IDLE}));
      end
   endtask
   task automatic rx_frame();
      int s, i;
      s = -1;
      rxq.delete();
      foreach (g[k]) begin
         @(posedge i_lclk);
         rx_code <= g[k];
      end
      repeat (40) begin
         @(posedge i_lclk);
         rx_code <= CG_IDLE;
      end
      foreach (rxq[k]) begin
         if (s < 0 && rxq[k].crs === 1'b1) s = k;
      end
      if (g[1] !== CG_K) begin
         check(16'(s), 16'hffff);
      end else begin
         i = 0;
         while (g[i] !== CG_T && g[i] !== CG_IDLE) begin
            check(16'(rxq[s+i]), 16'(rx_exp(g[i], i)));
            i++;
         end
         if (g[i] === CG_T) check(16'({rxq[s+i][6:4], rxq[s+i+1][6:4], rxq[s+i+2][6:4]}), 16'h0000);
         else check(16'({rxq[s+i][5:4], rxq[s+i+1][5:4]}), 16'h0008);
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge i_mclk);
      fails++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge i_lclk);
      i_reset_n <= 1'b1;
      repeat (8) @(negedge i_lclk);
      check(16'(tx_code), 16'(CG_IDLE));
      check(16'({link, link_ext, flp}), 16'h0001);
      @(posedge i_mclk);
      i_dscr_lock <= 1'b1;
      i_link10_raw <= 1'b1;
      repeat (195) @(negedge i_mclk);
      check(16'(link), 16'h0000);
      wait_link(1'b1);
      check(16'({link, link_ext, link10, flp}), 16'h000c);
      repeat (3) @(posedge i_lclk);
      q = {5'h05, 5'h05};
      for (int k = 0; k < 16; k++) q.push_back(5'(k));
      q.push_back(5'h1a);
      tx_frame(1'b1);
      g = {CG_J, CG_K};
      for (int k = 0; k < 16; k++) g.push_back(ENC[k]);
      g.push_back(CG_T);
      g.push_back(CG_R);
      rx_frame();
      repeat (4) begin
         q = {5'h05, 5'h05};
         g = {CG_J, CG_K};
         seed = lfsr(seed);
         repeat (3 + seed[2:0]) begin
            seed = lfsr(seed);
            q.push_back({seed[7:4] == 4'h0, seed[3:0]});
            g.push_back(ENC[seed[11:8]]);
         end
         g.push_back(CG_T);
         g.push_back(CG_R);
         tx_frame(1'b1);
         rx_frame();
      end
      g = {CG_J, CG_K, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19, CG_H, CG_T, CG_R};
      rx_frame();
      g = {CG_J, CG_K, ENC[3], 5'h00, ENC[9], CG_IDLE};
      rx_frame();
      g = {CG_J, CG_IDLE};
      rx_frame();
      n = 0;
      @(negedge i_mclk);
      p = txclk;
      repeat (40) begin
         @(negedge i_mclk);
         if (txclk === 1'b1 && p === 1'b0) n++;
         p = txclk;
         check(16'(rxclk), 16'(txclk));
      end
      check(16'(n), 16'h000a);
      irqs = 0;
      rsts = 0;
      @(posedge i_lclk);
      rx_code <= ENC[0];
      wait_link(1'b0);
      repeat (4) @(negedge i_mclk);
      check(16'({link, link_ext, flp}), 16'h0001);
      check(16'({irqs[3:0], rsts[3:0]}), 16'h0011);
      @(posedge i_lclk);
      rx_code <= CG_IDLE;
      tx_frame(1'b0);
      @(posedge i_mclk);
      // diagnostic transmit only, with negotiation off
      i_an_enable <= 1'b0;
      i_link_override <= 1'b1;
      repeat (4) @(negedge i_lclk);
      check(16'(flp), 16'h0000);
      tx_frame(1'b1);
      @(posedge i_mclk);
      i_dscr_lock <= 1'b0;
      repeat (6) @(negedge i_mclk);
      check(16'(link10), 16'h0001);
      @(posedge i_mclk);
      i_ce <= 1'b0;
      repeat (3) @(negedge i_mclk);
      p = txclk;
      repeat (6) @(negedge i_mclk);
      check(16'(txclk), 16'(p));
      stop_test();
   end
endmodule
